// >>> env_seq_map.vh
// constants for the environmental sensor mode sequencer
// assumes inclusion by bare name from the design files
`ifndef ENV_SEQ_MAP_VH
`define ENV_SEQ_MAP_VH
// register byte addresses
`define ADDR_CTRL_MEAS 8'h00
`define ADDR_CTRL_HUM 8'h04
`define ADDR_CTRL_GAS 8'h08
`define ADDR_STATUS 8'h0C
`define ADDR_HEAT_BASE 8'h40
`define ADDR_WAIT_BASE 8'h80
`define SLOT_STRIDE 8'h04
// mode codes
`define MODE_SLEEP 2'h0
`define MODE_FORCED 2'h1
// field positions
`define F_MODE_LO 0
`define F_OSP_LO 2
`define F_OST_LO 5
`define F_OSH_LO 0
`define F_PROF_LO 0
`define F_GAS_EN 4
// reset values
`define RST_MODE 2'h0
`define RST_OS 3'h0
`define RST_PROF 4'h0
`define RST_BYTE 8'h00
// timing
`define CONV_TIME_NS 1000
`define CLK_PERIOD_NS 10
`define WAIT_UNIT_CYC 16
`define PROFILES 10
`endif

// >>> step_timer.v
// step timer: counts a programmed number of cycles then pulses done
// assumes start is a one-cycle pulse from the sequencer on the same clock
`timescale 1ns/1ps
`include "env_seq_map.vh"
module step_timer #(
  parameter W = 16
) (
  input wire i_sys_clk,
  input wire i_rst,
  input wire i_start,
  input wire [W-1:0] i_len,
  output wire o_done
);
  reg [W-1:0] cnt_q;
  reg run_q;
  reg done_q;
  // load on start, count down, flag the last cycle
  always @(posedge i_sys_clk or posedge i_rst) begin
    if (i_rst) begin
      cnt_q <= {W{1'b0}};
      run_q <= 1'b0;
      done_q <= 1'b0;
    end else begin
      done_q <= 1'b0;
      if (i_start) begin
        cnt_q <= i_len;
        run_q <= 1'b1;
      end else if (run_q) begin
        if (cnt_q <= {{(W-1){1'b0}}, 1'b1}) begin
          run_q <= 1'b0;
          done_q <= 1'b1;
        end else begin
          cnt_q <= cnt_q - {{(W-1){1'b0}}, 1'b1};
        end
      end
    end
  end
  assign o_done = done_q;
endmodule // step_timer

// >>> env_sensor_mode_sequencer.v
// mode control and forced measurement sequencing of an environmental sensor
// assumes a host on the same clock using the plain strobe register port
//
// How it works
// - reset lands in sleep, no conversions
// - two-bit mode field, 00 is sleep
// - code 01 runs one cycle, then sleep
// - mode writes during measurement wait until end
// - while pending, drop all control writes
// - order temperature, pressure, humidity, gas
// - ten heater setpoint and duration slots
// - heater on only during gas step
// - four-bit profile select picks heater slot
// - gas step runs only when enabled
// - oversampling zero skips that step
//
// The register offsets and strobed register access were decided locally.
`timescale 1ns/1ps
`include "env_seq_map.vh"
module env_sensor_mode_sequencer #(
  parameter TW = 16
) (
  input wire i_sys_clk,
  input wire i_rst,
  input wire [7:0] i_addr,
  input wire [7:0] i_wdata,
  input wire i_wr,
  input wire i_rd,
  output reg [7:0] o_rdata,
  output wire o_heater_on,
  output wire [7:0] o_heater_setpoint,
  output wire [2:0] o_conv_step,
  output wire o_conv_active
);
  // sequencer states and fixed step lengths
  localparam [2:0] S_IDLE = 3'd0;
  localparam [2:0] S_TEMP = 3'd1;
  localparam [2:0] S_PRES = 3'd2;
  localparam [2:0] S_HUM = 3'd3;
  localparam [2:0] S_GAS = 3'd4;
  localparam [TW-1:0] CONV_CYC = `CONV_TIME_NS / `CLK_PERIOD_NS;
  localparam [TW-1:0] WAIT_CYC = `WAIT_UNIT_CYC;

  // configuration, heater tables and sequencer state
  reg [1:0] mode_q;
  reg [2:0] os_t_q, os_p_q, os_h_q;
  reg [3:0] prof_q;
  reg gas_en_q;
  reg [7:0] heat_q [0:`PROFILES-1];
  reg [7:0] wait_q [0:`PROFILES-1];
  reg pend_q;
  reg [1:0] pend_mode_q;
  reg [2:0] state_q;
  reg [2:0] state_d;
  reg start_q;
  reg [TW-1:0] len_d;
  wire step_done;
  wire busy;
  integer k;
  integer j;

  // slot index decode used for heater and wait tables
  function slot_ok;
    input [3:0] idx;
    begin
      slot_ok = (idx < `PROFILES);
    end
  endfunction

  // address of table entry idx above the given base
  function [7:0] slot_addr;
    input [7:0] base;
    input integer idx;
    begin
      slot_addr = base + `SLOT_STRIDE * idx[7:0];
    end
  endfunction

  // next step after the given one, skipping disabled steps
  function [2:0] next_step;
    input [2:0] cur;
    input [2:0] ot, op, oh;
    input ge;
    input [3:0] pr;
    begin
      next_step = S_IDLE;
      if (cur == S_IDLE && ot != 3'h0) next_step = S_TEMP;
      else if (cur <= S_TEMP && op != 3'h0) next_step = S_PRES;
      else if (cur <= S_PRES && oh != 3'h0) next_step = S_HUM;
      else if (cur <= S_HUM && ge && slot_ok(pr)) next_step = S_GAS;
    end
  endfunction

  assign busy = (state_q != S_IDLE);
  wire wr_ok = i_wr && !pend_q;
  // still measuring after this edge; the last step cycle takes writes
  wire hold_wr = busy && (state_d != S_IDLE);

  // step timer sets each conversion length
  step_timer #(.W(TW)) u_timer (
    .i_sys_clk(i_sys_clk),
    .i_rst(i_rst),
    .i_start(start_q),
    .i_len(len_d),
    .o_done(step_done)
  );

  // sequencer next state
  always @* begin
    state_d = state_q;
    case (state_q)
      S_IDLE: begin
        if (mode_q == `MODE_FORCED) begin
          state_d = next_step(S_IDLE, os_t_q, os_p_q, os_h_q,
            gas_en_q, prof_q);
        end
      end
      S_TEMP, S_PRES, S_HUM, S_GAS: begin
        if (step_done) begin
          state_d = next_step(state_q, os_t_q, os_p_q, os_h_q,
            gas_en_q, prof_q);
        end
      end
      default: state_d = S_IDLE;
    endcase
  end

  // step length: gas uses the selected duration, others a fixed time
  always @* begin
    len_d = CONV_CYC;
    if (state_q == S_GAS && slot_ok(prof_q)) begin
      len_d = wait_q[prof_q] * WAIT_CYC;
      if (len_d == {TW{1'b0}}) len_d = CONV_CYC;
    end
  end

  // state, mode and pending command
  always @(posedge i_sys_clk or posedge i_rst) begin
    if (i_rst) begin
      state_q <= S_IDLE;
      mode_q <= `RST_MODE;
      pend_q <= 1'b0;
      pend_mode_q <= `RST_MODE;
      start_q <= 1'b0;
    end else begin
      state_q <= state_d;
      start_q <= (state_d != S_IDLE) && (state_d != state_q);
      if (busy && state_d == S_IDLE) begin
        if (pend_q) begin
          mode_q <= pend_mode_q;
          pend_q <= 1'b0;
        end else begin
          mode_q <= `MODE_SLEEP;
        end
      end else if (!busy && state_d == S_IDLE &&
                   mode_q == `MODE_FORCED) begin
        mode_q <= `MODE_SLEEP;
      end
      if (wr_ok && i_addr == `ADDR_CTRL_MEAS) begin
        if (hold_wr) begin
          pend_q <= 1'b1;
          pend_mode_q <= i_wdata[`F_MODE_LO+1:`F_MODE_LO];
        end else begin
          mode_q <= i_wdata[`F_MODE_LO+1:`F_MODE_LO];
        end
      end
    end
  end

  // control registers, frozen while a mode change waits
  always @(posedge i_sys_clk or posedge i_rst) begin
    if (i_rst) begin
      os_t_q <= `RST_OS;
      os_p_q <= `RST_OS;
      os_h_q <= `RST_OS;
      prof_q <= `RST_PROF;
      gas_en_q <= 1'b0;
      for (k = 0; k < `PROFILES; k = k + 1) begin
        heat_q[k] <= `RST_BYTE;
        wait_q[k] <= `RST_BYTE;
      end
    end else if (wr_ok) begin
      if (i_addr == `ADDR_CTRL_MEAS && !hold_wr) begin
        os_t_q <= i_wdata[`F_OST_LO+2:`F_OST_LO];
        os_p_q <= i_wdata[`F_OSP_LO+2:`F_OSP_LO];
      end
      if (i_addr == `ADDR_CTRL_HUM)
        os_h_q <= i_wdata[`F_OSH_LO+2:`F_OSH_LO];
      if (i_addr == `ADDR_CTRL_GAS) begin
        prof_q <= i_wdata[`F_PROF_LO+3:`F_PROF_LO];
        gas_en_q <= i_wdata[`F_GAS_EN];
      end
      for (k = 0; k < `PROFILES; k = k + 1) begin
        if (i_addr == slot_addr(`ADDR_HEAT_BASE, k))
          heat_q[k] <= i_wdata;
        if (i_addr == slot_addr(`ADDR_WAIT_BASE, k))
          wait_q[k] <= i_wdata;
      end
    end
  end

  // read data, valid the cycle after the read strobe
  always @(posedge i_sys_clk or posedge i_rst) begin
    if (i_rst) begin
      o_rdata <= `RST_BYTE;
    end else if (i_rd) begin
      o_rdata <= `RST_BYTE;
      if (i_addr == `ADDR_CTRL_MEAS)
        o_rdata <= {os_t_q, os_p_q, mode_q};
      if (i_addr == `ADDR_CTRL_HUM) o_rdata <= {5'h00, os_h_q};
      if (i_addr == `ADDR_CTRL_GAS) o_rdata <= {3'h0, gas_en_q, prof_q};
      if (i_addr == `ADDR_STATUS)
        o_rdata <= {4'h0, state_q, busy};
      for (j = 0; j < `PROFILES; j = j + 1) begin
        if (i_addr == slot_addr(`ADDR_HEAT_BASE, j)) o_rdata <= heat_q[j];
        if (i_addr == slot_addr(`ADDR_WAIT_BASE, j)) o_rdata <= wait_q[j];
      end
    end
  end

  // heater and step outputs follow the sequencer state
  assign o_heater_on = (state_q == S_GAS);
  assign o_heater_setpoint = (state_q == S_GAS) ? heat_q[prof_q] :
    `RST_BYTE;
  assign o_conv_step = state_q;
  assign o_conv_active = busy;
endmodule // env_sensor_mode_sequencer

// >>> env_seq_chk_sva.sv
// checker: timing relations on the sequencer outputs
// assumes a bind from the testbench top onto the design ports
`timescale 1ns/1ps
module env_seq_chk (
  input wire i_sys_clk,
  input wire i_rst,
  input wire [7:0] i_addr,
  input wire [7:0] i_wdata,
  input wire i_wr,
  input wire [2:0] o_conv_step,
  input wire o_conv_active,
  input wire o_heater_on,
  input wire [7:0] o_heater_setpoint
);
  default clocking cb @(posedge i_sys_clk);
  endclocking
  default disable iff (i_rst);
  heat_gas_a: assert property (o_heater_on == (o_conv_step == 3'h4))
    else $error("heater outside gas step");
  set_off_a: assert property (!o_heater_on |-> o_heater_setpoint == 8'h00)
    else $error("setpoint while heater off");
  step_order_a: assert property ($changed(o_conv_step) && o_conv_step != 3'h0
    |-> $past(o_conv_step) < o_conv_step) else $error("step order broken");
  step_hold_a: assert property ($changed(o_conv_step) && o_conv_step != 3'h0
    |-> ##1 $stable(o_conv_step) [*8]) else $error("step too short");
  busy_step_a: assert property (o_conv_step != 3'h0 |-> o_conv_active)
    else $error("step without busy");
  forced_start_a: assert property (i_wr && i_addr == 8'h00 && !o_conv_active
    && i_wdata[1:0] == 2'h1 && i_wdata[7:5] != 3'h0
    |-> ##2 o_conv_active && o_conv_step == 3'h1) else $error("no start");
  end_idle_a: assert property ($fell(o_conv_active) |-> o_conv_step == 3'h0)
    else $error("end with step set");
  self_start_a: assert property ($rose(o_conv_active)
    |-> $past(i_wr, 2) || $past(o_conv_active, 2))
    else $error("start without write");
  defer_mode_a: assert property (o_conv_active && i_wr && i_addr == 8'h00
    |-> ##1 o_conv_active) else $error("mode write cut cycle");
endmodule // env_seq_chk

// >>> env_host.sv
// host model: drives the plain strobe register port
// assumes the device samples strobes on the rising clock edge
`timescale 1ns/1ps
module env_host (
  input wire i_sys_clk,
  input wire [7:0] i_rdata,
  output reg [7:0] o_addr = 8'h00,
  output reg [7:0] o_wdata = 8'h00,
  output reg o_wr = 1'b0,
  output reg o_rd = 1'b0
);
  // one-cycle write; callers set all fields before the mode write, except the gas write that t_pend sends after it
  task wr_reg(input [7:0] a, input [7:0] d);
    begin
      @(posedge i_sys_clk);
      o_addr <= a;
      o_wdata <= d;
      o_wr <= 1'b1;
      @(posedge i_sys_clk);
      o_wr <= 1'b0;
    end
  endtask
  // one-cycle read, data taken in the following cycle
  task rd_reg(input [7:0] a, output [7:0] d);
    begin
      @(posedge i_sys_clk);
      o_addr <= a;
      o_rd <= 1'b1;
      @(posedge i_sys_clk);
      o_rd <= 1'b0;
      #1 d = i_rdata;
    end
  endtask
endmodule // env_host

// >>> env_sensor_mode_sequencer_test.sv
// testbench top for the mode sequencer
// assumes host model and checker are compiled before it
`timescale 1ns/1ps
module env_sensor_mode_sequencer_test;
  reg clk = 1'b0;
  reg rst = 1'b1;
  wire [7:0] addr, wdata, rdata, sp;
  wire wr, rd, heat, act;
  wire [2:0] step;
  reg [11:0] seq = 12'h000;
  reg [7:0] d, sp_q = 8'h00;
  integer errors = 0, num_checks = 0, cyc = 0, n;
  always #5 clk = ~clk;
  env_host u_env_host (.i_sys_clk(clk), .i_rdata(rdata), .o_addr(addr),
    .o_wdata(wdata), .o_wr(wr), .o_rd(rd));
  env_sensor_mode_sequencer u_env_sensor_mode_sequencer (.i_sys_clk(clk),
    .i_rst(rst), .i_addr(addr), .i_wdata(wdata), .i_wr(wr), .i_rd(rd),
    .o_rdata(rdata), .o_heater_on(heat), .o_heater_setpoint(sp),
    .o_conv_step(step), .o_conv_active(act));
  // step order log, heater code capture and cycle ceiling
  always @(posedge clk) begin
    cyc <= cyc + 1;
    if (step !== 3'h0 && step !== seq[2:0])
      seq <= {seq[8:0], step};
    if (heat === 1'b1)
      sp_q <= sp;
    if (cyc == 8000) begin
      errors = errors + 1;
      test_done;
    end
  end
  task check(input string nm, input [11:0] e, input [11:0] g);
    begin
      num_checks = num_checks + 1;
      if (g !== e) begin
        errors = errors + 1;
        $display("[ERR] %s exp %h got %h", nm, e, g);
      end
    end
  endtask
  task test_done;
    begin
      $display("checks %0d errors %0d", num_checks, errors);
      if (errors == 0 && num_checks > 0)
        $display("TB: PASS");
      else
        $display("TB: FAIL");
      $finish;
    end
  endtask
  // wait out a measurement within a bounded count
  task wait_end;
    begin
      repeat (3) @(posedge clk);
      n = 0;
      while (act === 1'b1 && n < 2000) begin
        @(posedge clk);
        n = n + 1;
      end
      #1;
    end
  endtask
  task run(input [7:0] ctrl, input [11:0] exp);
    begin
      seq = 12'h000;
      u_env_host.wr_reg(8'h00, ctrl);
      wait_end;
      check("order", exp, seq);
    end
  endtask
  task t_reset;
    begin
      check("idle", 12'h000, {9'h000, step});
      u_env_host.rd_reg(8'h0C, d);
      check("status", 12'h000, {4'h0, d});
      u_env_host.rd_reg(8'h3C, d);
      check("unmapped", 12'h000, {4'h0, d});
      $display("test reset done");
    end
  endtask
  task t_full;
    begin
      u_env_host.wr_reg(8'h04, 8'h01);
      u_env_host.wr_reg(8'h40, 8'h5A);
      u_env_host.wr_reg(8'h80, 8'h02);
      u_env_host.wr_reg(8'h08, 8'h10);
      run(8'h25, 12'h29C);
      check("setpoint", 12'h05A, {4'h0, sp_q});
      u_env_host.rd_reg(8'h00, d);
      check("mode", 12'h024, {4'h0, d});
      $display("test full done");
    end
  endtask
  task t_skip;
    begin
      u_env_host.wr_reg(8'h04, 8'h00);
      u_env_host.wr_reg(8'h08, 8'h00);
      run(8'h05, 12'h002);
      u_env_host.wr_reg(8'h08, 8'h1A);
      run(8'h21, 12'h001);
      $display("test skip done");
    end
  endtask
  task t_pend;
    begin
      u_env_host.wr_reg(8'h08, 8'h00);
      u_env_host.wr_reg(8'h00, 8'h21);
      repeat (20) @(posedge clk);
      u_env_host.wr_reg(8'h00, 8'h00);
      u_env_host.wr_reg(8'h08, 8'h15);
      #1 check("busy", 12'h001, {11'h000, act});
      wait_end;
      u_env_host.rd_reg(8'h08, d);
      check("gas reg", 12'h000, {4'h0, d});
      u_env_host.rd_reg(8'h00, d);
      check("ctrl", 12'h020, {4'h0, d});
      $display("test pend done");
    end
  endtask
  task t_slot;
    begin
      u_env_host.wr_reg(8'h64, 8'hC3);
      u_env_host.wr_reg(8'hA4, 8'h01);
      u_env_host.wr_reg(8'h68, 8'h77);
      u_env_host.wr_reg(8'h08, 8'h19);
      run(8'h21, 12'h00C);
      check("slot9 code", 12'h0C3, {4'h0, sp_q});
      u_env_host.rd_reg(8'h64, d);
      check("slot9", 12'h0C3, {4'h0, d});
      u_env_host.rd_reg(8'h68, d);
      check("slot10", 12'h000, {4'h0, d});
      $display("test slot done");
    end
  endtask
  task t_again;
    begin
      u_env_host.wr_reg(8'h08, 8'h00);
      u_env_host.wr_reg(8'h00, 8'h21);
      repeat (20) @(posedge clk);
      u_env_host.wr_reg(8'h00, 8'h21);
      wait_end;
      check("restart", 12'h001, {11'h000, act});
      wait_end;
      u_env_host.rd_reg(8'h00, d);
      check("sleep", 12'h020, {4'h0, d});
      $display("test again done");
    end
  endtask
  initial begin
    repeat (6) @(posedge clk);
    rst <= 1'b0;
    @(posedge clk);
    #1 t_reset;
    t_full;
    t_skip;
    t_pend;
    t_slot;
    t_again;
    test_done;
  end
endmodule // env_sensor_mode_sequencer_test
bind env_sensor_mode_sequencer env_seq_chk u_env_seq_chk (
  .i_sys_clk(i_sys_clk), .i_rst(i_rst), .i_addr(i_addr), .i_wdata(i_wdata),
  .i_wr(i_wr), .o_conv_step(o_conv_step), .o_conv_active(o_conv_active),
  .o_heater_on(o_heater_on), .o_heater_setpoint(o_heater_setpoint));
